//--- rtl/usba_top.v
// Shadow receive/transmit buffer access for the second serial port, AXI4-Lite.
// Assumes the receiver delivers bytes as pulses and the serialiser drains bytes.
// Operation
// - Sixteen word-spaced aliases for buffer access
// - Read returns byte from serial or infrared
// - Read data valid only while ready flag
// - FIFO off: new byte overwrites, flag overrun
// - FIFO on: read pops receive FIFO head
// - Full receive FIFO drops byte, flags overrun
// - Write queues byte for serial/infrared output
// - FIFO off: one write clears holding empty
// - FIFO off: later writes replace pending byte
// - FIFO on: accept writes up to depth
// - Write to full transmit FIFO discarded
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "usba_defs.vh"
module usba_top #(
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        sin_valid,
	input  wire [7:0]  sin_byte,
	input  wire        sir_in_valid,
	input  wire [7:0]  sir_in_byte,
	output wire        tx_valid,
	output wire [7:0]  tx_byte,
	output wire        tx_ir_sel,
	input  wire        tx_ready,
	output wire        irq
);
	// Write channel capture
	reg        aw_q;          // Address held
	reg [31:0] awaddr_q;
	reg        w_q;           // Data held
	reg [31:0] wdata_q;
	reg [3:0]  wstrb_q;
	// Control and status
	reg        fifo_en_q;     // FIFO enable, control bit 0
	reg        ir_mode_q;     // Infrared mode select
	reg [7:0]  rx_buf_q;      // Receive buffer when FIFO off
	reg        rx_dr_q;       // Ready flag when FIFO off
	reg        ovr_q;         // Overrun, cleared on status read
	reg [7:0]  thr_q;         // Holding byte when FIFO off
	reg        thr_full_q;    // Holding byte pending
	reg [2:0]  irq_stat_q;    // Sticky events
	reg [2:0]  irq_en_q;      // Event enables
	// Decoded strobes
	wire       wr_go;
	wire       rd_go;
	wire       wr_shadow;
	wire       rd_shadow;
	wire       rd_known;
	wire       wr_known;
	wire [31:0] rd_word_addr;
	// Receive path
	wire       rx_in_valid;
	wire [7:0] rx_in_byte;
	wire [7:0] rxf_head;
	wire       rxf_empty;
	wire       rxf_full;
	wire       rx_ready_flag;
	wire [7:0] rx_head_byte;
	wire       rx_pop;
	// Transmit path
	wire [7:0] txf_head;
	wire       txf_empty;
	wire       txf_full;
	wire       tx_holding_empty_flag;
	wire       tx_take;
	wire       tx_push;
	wire       ovr_event;
	wire [31:0] lsr_word;
	reg  [31:0] rd_mux;

	// Shadow window spans sixteen words around registers 6 and 7
	// Window straddles a 64-byte boundary: words c..f of one block, 0..b of next
	function in_shadow;
		input [31:0] a;
		reg   [31:0] blk;  // 64-byte block holding the first alias
		begin
			blk       = `USBA_SHADOW_FIRST >> 6;
			in_shadow = (a[1:0] == 2'b00)
				&& ((({6'h00, a[31:6]} == blk) && (a[5:2] >= 4'hc))
				|| (({6'h00, a[31:6]} == blk + 32'h1) && (a[5:2] <= 4'hb)));
		end
	endfunction

	// Accept address and data in either order; one write at a time
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign wr_go         = aw_q && w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go         = s_axi_arvalid && s_axi_arready;
	assign rd_word_addr  = s_axi_araddr;
	assign wr_shadow     = wr_go && in_shadow(awaddr_q) && wstrb_q[0];
	assign rd_shadow     = rd_go && in_shadow(rd_word_addr);
	assign wr_known      = in_shadow(awaddr_q) || awaddr_q == `USBA_CTRL_ADDR
		|| awaddr_q == `USBA_IRQ_EN_ADDR || awaddr_q == `USBA_IRQ_CLR_ADDR
		|| awaddr_q == `USBA_LSR_ADDR || awaddr_q == `USBA_IRQ_STAT_ADDR;
	assign rd_known      = in_shadow(rd_word_addr) || rd_word_addr == `USBA_CTRL_ADDR
		|| rd_word_addr == `USBA_LSR_ADDR || rd_word_addr == `USBA_IRQ_STAT_ADDR
		|| rd_word_addr == `USBA_IRQ_EN_ADDR || rd_word_addr == `USBA_IRQ_CLR_ADDR;

	// Source follows mode: serial or infrared receiver
	assign rx_in_valid = ir_mode_q ? sir_in_valid : sin_valid;
	assign rx_in_byte  = ir_mode_q ? sir_in_byte : sin_byte;

	// Receive FIFO; a push when full is dropped inside
	usba_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_rxf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.flush     (!fifo_en_q),
		.push      (fifo_en_q && rx_in_valid),
		.push_data (rx_in_byte),
		.pop       (rx_pop),
		.head      (rxf_head),
		.empty     (rxf_empty),
		.full      (rxf_full)
	);

	assign rx_pop        = rd_shadow && fifo_en_q;
	assign rx_ready_flag = fifo_en_q ? !rxf_empty : rx_dr_q;
	assign rx_head_byte  = fifo_en_q ? rxf_head : rx_buf_q;
	// Overrun: unread byte overwritten, or FIFO full on arrival
	assign ovr_event = rx_in_valid && (fifo_en_q ? rxf_full : rx_dr_q && !rd_shadow);

	// Transmit FIFO; writes into a full FIFO are lost
	usba_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_txf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.flush     (!fifo_en_q),
		.push      (tx_push),
		.push_data (wdata_q[7:0]),
		.pop       (tx_take && fifo_en_q),
		.head      (txf_head),
		.empty     (txf_empty),
		.full      (txf_full)
	);

	assign tx_push   = wr_shadow && fifo_en_q;
	assign tx_holding_empty_flag      = fifo_en_q ? txf_empty : !thr_full_q;
	assign tx_valid  = fifo_en_q ? !txf_empty : thr_full_q;
	assign tx_byte   = fifo_en_q ? txf_head : thr_q;
	assign tx_ir_sel = ir_mode_q;
	assign tx_take   = tx_valid && tx_ready;
	assign lsr_word  = {26'h0, tx_holding_empty_flag, 3'b000, ovr_q, rx_ready_flag};
	assign irq       = |(irq_stat_q & irq_en_q);

	// Write channel capture registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= 32'h0;
			wdata_q  <= 32'h0;
			wstrb_q  <= 4'h0;
		end else if (wr_go) begin
			aw_q <= 1'b0;
			w_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// Write response, one cycle after both halves held
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `USBA_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_known ? `USBA_RESP_OKAY : `USBA_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read data mux; upper bits of shadow always zero
	always @* begin
		rd_mux = 32'h0;
		if (in_shadow(rd_word_addr))
			rd_mux = {24'h0, rx_head_byte};
		else if (rd_word_addr == `USBA_CTRL_ADDR)
			rd_mux = {30'h0, ir_mode_q, fifo_en_q};
		else if (rd_word_addr == `USBA_LSR_ADDR)
			rd_mux = lsr_word;
		else if (rd_word_addr == `USBA_IRQ_STAT_ADDR)
			rd_mux = {29'h0, irq_stat_q};
		else if (rd_word_addr == `USBA_IRQ_EN_ADDR)
			rd_mux = {29'h0, irq_en_q};
	end

	// Read response, one cycle after address taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `USBA_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_known ? `USBA_RESP_OKAY : `USBA_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control register
	always @(posedge aclk) begin
		if (!aresetn) begin
			fifo_en_q <= 1'b0;
			ir_mode_q <= 1'b0;
		end else if (wr_go && awaddr_q == `USBA_CTRL_ADDR && wstrb_q[0]) begin
			fifo_en_q <= wdata_q[`USBA_CTRL_FIFO_EN];
			ir_mode_q <= wdata_q[`USBA_CTRL_IR_MODE];
		end
	end

	// Non-FIFO receive buffer; arrival wins over a same-cycle read
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_buf_q <= `USBA_DATA_RESET;
			rx_dr_q  <= 1'b0;
		end else if (!fifo_en_q && rx_in_valid) begin
			rx_buf_q <= rx_in_byte;
			rx_dr_q  <= 1'b1;
		end else if (rd_shadow || fifo_en_q) begin
			rx_dr_q  <= 1'b0;
		end
	end

	// Overrun flag; new overrun wins over status-read clear
	always @(posedge aclk) begin
		if (!aresetn)
			ovr_q <= 1'b0;
		else if (ovr_event)
			ovr_q <= 1'b1;
		else if (rd_go && rd_word_addr == `USBA_LSR_ADDR)
			ovr_q <= 1'b0;
	end

	// Non-FIFO holding byte; master is expected to respect empty flag
	always @(posedge aclk) begin
		if (!aresetn) begin
			thr_q      <= `USBA_DATA_RESET;
			thr_full_q <= 1'b0;
		end else if (wr_shadow && !fifo_en_q) begin
			thr_q      <= wdata_q[7:0];
			thr_full_q <= 1'b1;
		end else if (tx_take || fifo_en_q) begin
			thr_full_q <= 1'b0;
		end
	end

	// Interrupt enable and sticky status; set wins over clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_q   <= 3'b000;
			irq_stat_q <= 3'b000;
		end else begin
			if (wr_go && awaddr_q == `USBA_IRQ_EN_ADDR && wstrb_q[0])
				irq_en_q <= wdata_q[2:0];
			irq_stat_q <= (irq_stat_q & ~((wr_go && awaddr_q == `USBA_IRQ_CLR_ADDR
				&& wstrb_q[0]) ? wdata_q[2:0] : 3'b000))
				| {tx_take, ovr_event, rx_in_valid};
		end
	end
endmodule // usba_top

//--- rtl/usba_defs.vh
// Constants for the shadow buffer access block: addresses, fields, resets.
// Assumes inclusion by bare name from rtl/ and verif/ files.
`ifndef USBA_DEFS_VH
`define USBA_DEFS_VH
`define USBA_SHADOW6_ADDR  32'h50001148
`define USBA_SHADOW7_ADDR  32'h5000114c
`define USBA_SHADOW_WORDS  16
`define USBA_SHADOW_FIRST  32'h50001130
`define USBA_CTRL_ADDR     32'h50001200
`define USBA_LSR_ADDR      32'h50001204
`define USBA_IRQ_STAT_ADDR 32'h50001208
`define USBA_IRQ_EN_ADDR   32'h5000120c
`define USBA_IRQ_CLR_ADDR  32'h50001210
`define USBA_CTRL_FIFO_EN  0
`define USBA_CTRL_IR_MODE  1
`define USBA_LSR_DR        0
`define USBA_LSR_OE        1
`define USBA_LSR_TX_HOLDING_EMPTY_FLAG      5
`define USBA_IRQ_RX        0
`define USBA_IRQ_OVR       1
`define USBA_IRQ_TXE       2
`define USBA_DATA_RESET    8'h00
`define USBA_RESP_OKAY     2'b00
`define USBA_RESP_SLVERR   2'b10
`endif

//--- rtl/usba_fifo.v
// Synchronous byte FIFO with drop-on-full write and registered level.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module usba_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             flush,
	input  wire             push,
	input  wire [WIDTH-1:0] push_data,
	input  wire             pop,
	output wire [WIDTH-1:0] head,
	output wire             empty,
	output wire             full
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
	reg [AW-1:0]    wr_q;            // Tail pointer
	reg [AW-1:0]    rd_q;            // Head pointer
	reg [AW:0]      cnt_q;           // Entries held
	wire            do_push;
	wire            do_pop;

	assign empty   = (cnt_q == {(AW+1){1'b0}});
	assign full    = (cnt_q == DEPTH[AW:0]);
	// Push on full is dropped; contents stay intact
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;
	assign head    = mem[rd_q];

	// Pointers and count
	always @(posedge aclk) begin
		if (!aresetn || flush) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (do_push)
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			if (do_pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			if (do_push && !do_pop)
				cnt_q <= cnt_q + 1'b1;
			else if (do_pop && !do_push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// Data array, no reset needed
	always @(posedge aclk) begin
		if (do_push)
			mem[wr_q] <= push_data;
	end
endmodule // usba_fifo

//--- verif/usba_top_sva.sv
// Checker for the shadow buffer block, bound to usba_top.
// Assumes rtl/ is on the include path.
`timescale 1ns/1ps
`include "usba_defs.vh"
module usba_top_sva (
	input wire        aclk,
	input wire        aresetn,
	input wire [31:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_wvalid,
	input wire        tx_valid,
	input wire        tx_ready,
	input wire        irq
);
	// Read address accepted this cycle
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	// Inside the sixteen-word alias window
	wire in_win = s_axi_araddr >= `USBA_SHADOW_FIRST &&
		s_axi_araddr <= `USBA_SHADOW_FIRST + 32'h3c;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	win_okay_a:
	assert property (ar_hs && in_win |=> s_axi_rvalid && s_axi_rresp == 2'b00)
		else $error("shadow read not answered okay");
	unmapped_err_a:
	assert property (ar_hs && s_axi_araddr == 32'h50001170 |=>
		s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	upper_zero_a:
	assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	rdata_hold_a:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	resp_hold_a:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
	busy_refuse_a:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	tx_hold_a:
	assert property (tx_valid && !tx_ready && !s_axi_wvalid |=> tx_valid)
		else $error("pending byte lost");
	tx_fall_a:
	assert property ($fell(tx_valid) |-> $past(tx_ready) || $past(s_axi_wvalid) ||
		$past(s_axi_wvalid, 2)) else $error("byte vanished untaken");
	// Main traffic seen
	cover property (irq);
	cover property (tx_valid && tx_ready);
	cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // usba_top_sva
bind usba_top usba_top_sva chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_awready, .s_axi_wready, .s_axi_wvalid, .tx_valid, .tx_ready, .irq);

//--- verif/usba_ser_model.sv
// Serialiser stand-in: takes bytes unless stalled, logs them in order.
// Assumes the bench drives stall at rising edges.
`timescale 1ns/1ps
module usba_ser_model (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       tx_valid,
	input  wire [7:0] tx_byte,
	input  wire       stall,
	output wire       tx_ready
);
	reg [7:0] log_q [0:31]; // Taken bytes, wraps at 32
	integer   cnt_q;        // Bytes taken so far
	// No answer while stalled, prompt otherwise
	assign tx_ready = !stall;
	// Log every accepted byte
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 0;
		end else if (tx_valid && tx_ready) begin
			log_q[cnt_q % 32] <= tx_byte;
			cnt_q <= cnt_q + 1;
		end
	end
endmodule // usba_ser_model

//--- verif/uart_shadow_buffer_access_tb.sv
// Self-checking bench for usba_top with a serialiser model.
// Assumes rtl/ is on the include path.
`timescale 1ns/1ps
`include "usba_defs.vh"
`define USBA_CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module uart_shadow_buffer_access_tb;
	reg        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	reg        arvalid = 0, rready = 0, sin_v = 0, sir_v = 0, stall = 0;
	reg [31:0] awaddr = 0, wdata = 0, araddr = 0, d;
	reg [7:0]  sin_b = 0, sir_b = 0;
	reg [3:0]  wstrb = 4'h1; // Only byte lane 0 carries data
	reg [1:0]  rs, bs;
	wire       awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, tx_ir_sel, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] tx_byte;
	integer    err_total = 0, checks = 0, i, c0;
	localparam [31:0] SH6 = `USBA_SHADOW6_ADDR, SH7 = `USBA_SHADOW7_ADDR;
	localparam [31:0] LINE_STATUS_REGISTER = `USBA_LSR_ADDR, CTRL = `USBA_CTRL_ADDR;
	always #4 aclk = ~aclk;
	usba_top #(.DEPTH(16), .AW(4)) dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sin_valid(sin_v), .sin_byte(sin_b), .sir_in_valid(sir_v),
		.sir_in_byte(sir_b), .tx_valid, .tx_byte, .tx_ir_sel, .tx_ready, .irq);
	usba_ser_model m (.aclk, .aresetn, .tx_valid, .tx_byte, .stall, .tx_ready);
	task end_sim;
		begin
			$display("checks=%0d errors=%0d", checks, err_total);
			if (err_total == 0 && checks > 0) $display("TEST PASSED");
			else $display("TEST FAILED");
			$finish;
		end
	endtask
	// Write: both halves offered together, bready raised one cycle later, a cycle before bvalid
	task wr(input [31:0] a, input [31:0] v);
		integer n;
		reg ah, wh, bh;
		begin
			awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; n = 0; bh = 0;
			while (!bh) begin
				@(negedge aclk);
				ah = awvalid && awready; wh = wvalid && wready; bh = bvalid && bready;
				bs = bresp;
				@(posedge aclk);
				if (ah) awvalid <= 0;
				if (wh) wvalid <= 0;
				// Release only once the answer was taken at this edge
				bready <= !bh;
				n = n + 1;
				if (n > 50) begin err_total++; end_sim; end
			end
		end
	endtask
	// Read: rready raised one cycle after arvalid, together with rvalid, so the answer is taken at once
	task rd(input [31:0] a);
		integer n;
		reg ah, rh;
		begin
			araddr <= a; arvalid <= 1; n = 0; rh = 0;
			while (!rh) begin
				@(negedge aclk);
				ah = arvalid && arready; rh = rvalid && rready; d = rdata; rs = rresp;
				@(posedge aclk);
				if (ah) arvalid <= 0;
				// Release only once the answer was taken at this edge
				rready <= !rh;
				n = n + 1;
				if (n > 50) begin err_total++; end_sim; end
			end
		end
	endtask
	task rdchk(input [31:0] a, input [31:0] e);
		begin rd(a); `USBA_CHK(d, e) end
	endtask
	// One-cycle receive pulse on the serial or infrared side
	task rx(input [7:0] b, input ir);
		begin
			if (ir) begin sir_v <= 1; sir_b <= b; end
			else begin sin_v <= 1; sin_b <= b; end
			@(posedge aclk); sin_v <= 0; sir_v <= 0; @(posedge aclk);
		end
	endtask
	task pinchk(input e);
		begin @(negedge aclk); `USBA_CHK(irq, e) @(posedge aclk); end
	endtask
	task t_reset;
		begin
			rdchk(SH6, 32'h0);
			rdchk(SH7, 32'h0);
			rdchk(LINE_STATUS_REGISTER, 32'h20);
		end
	endtask
	// Unread byte overwritten, overrun flagged, ready drops on read
	task t_rx_plain;
		begin
			rx(8'h5a, 0); rdchk(LINE_STATUS_REGISTER, 32'h21);
			rx(8'h11, 0); rx(8'h22, 0); rdchk(LINE_STATUS_REGISTER, 32'h23);
			rdchk(SH7, 32'h22);
			rdchk(LINE_STATUS_REGISTER, 32'h20);
		end
	endtask
	task t_ir;
		begin
			wr(CTRL, 32'h2); rx(8'h3c, 1); rx(8'h99, 0);
			rdchk(SH6, 32'h3c);
			`USBA_CHK(tx_ir_sel, 1'b1)
			wr(CTRL, 32'h0);
		end
	endtask
	// Pending byte replaced while the serialiser stalls
	task t_tx_plain;
		begin
			stall <= 1; c0 = m.cnt_q;
			rdchk(LINE_STATUS_REGISTER, 32'h20);
			wr(SH6, 32'h41); rdchk(LINE_STATUS_REGISTER, 32'h0);
			wr(SH7, 32'hff42); @(negedge aclk); `USBA_CHK(tx_byte, 8'h42)
			@(posedge aclk); stall <= 0; repeat (4) @(posedge aclk);
			`USBA_CHK(m.cnt_q - c0, 1)
			`USBA_CHK(m.log_q[c0 % 32], 8'h42)
			rdchk(LINE_STATUS_REGISTER, 32'h20);
		end
	endtask
	// Seventeen bytes into a full receive queue, drained across all aliases
	task t_fifo_rx;
		begin
			wr(CTRL, 32'h1);
			for (i = 0; i < 17; i = i + 1) rx(i, 0);
			rdchk(LINE_STATUS_REGISTER, 32'h23);
			for (i = 0; i < 16; i = i + 1) rdchk(`USBA_SHADOW_FIRST + 4 * i, i);
			rdchk(LINE_STATUS_REGISTER, 32'h20);
		end
	endtask
	task t_fifo_tx;
		begin
			stall <= 1; c0 = m.cnt_q;
			for (i = 0; i < 17; i = i + 1) wr(SH6, 32'h80 + i);
			stall <= 0; repeat (40) @(posedge aclk);
			`USBA_CHK(m.cnt_q - c0, 16)
			for (i = 0; i < 16; i = i + 1) `USBA_CHK(m.log_q[(c0 + i) % 32], 8'h80 + i)
		end
	endtask
	// Interrupt raised, masked, unmasked, cleared; unmapped read refused
	task t_irq;
		begin
			wr(`USBA_IRQ_CLR_ADDR, 32'h7); wr(`USBA_IRQ_EN_ADDR, 32'h1); pinchk(0);
			rx(8'h77, 0); pinchk(1);
			wr(`USBA_IRQ_EN_ADDR, 32'h0); pinchk(0);
			wr(`USBA_IRQ_EN_ADDR, 32'h1); pinchk(1);
			wr(`USBA_IRQ_CLR_ADDR, 32'h1); pinchk(0);
			rdchk(32'h50001170, 32'h0); `USBA_CHK(rs, 2'b10)
			wr(32'h50001170, 32'h0); `USBA_CHK(bs, 2'b10)
			wr(SH6, 32'h0); `USBA_CHK(bs, 2'b00)
		end
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_reset; t_rx_plain; t_ir; t_tx_plain; t_fifo_rx; t_fifo_tx; t_irq;
		end_sim;
	end
endmodule // uart_shadow_buffer_access_tb
